// ==== hdl/pic_ctrl.sv ====
`timescale 1ns/1ps
module pic_ctrl
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Configuration
  input wire logic dedicated_mode,
  input wire logic [2:0] internal_level,
  input wire logic [2:0] vector_base,
  input wire logic [2:0] ack_pair_en,
  // Internal sources
  input wire logic [NUM_PER*EVT_W-1:0] internal_source_request,
  input wire logic [NUM_PER*EVT_W-1:0] event_mask,
  input wire logic [NUM_INT:1] source_mask,
  input wire logic [NUM_PIN-1:0] port_pins_n,
  // External sources
  input wire logic [2:0] priority_level_inputs_n,
  input wire logic level_seven_request_line_n,
  input wire logic level_six_request_line_n,
  input wire logic level_one_request_line_n,
  // Processor core
  input wire logic iack_strobe,
  input wire logic [2:0] iack_level,
  input wire logic eoi_strobe,
  input wire logic [3:0] eoi_source,
  output logic [2:0] core_level_reg,
  output logic vec_valid_reg,
  output logic [7:0] vec_data_reg,
  output logic [NUM_EXT-1:0] ext_ack_n_reg
);
  ////////////////////////////////////////////////////////////////////////
  pic_state_e state_reg;
  pic_state_e state_next;
  logic [5:0] ext_active;
  logic [NUM_PIN-1:0] pin_active;
  logic [NUM_PIN-1:0] pin_fall;
  logic [NUM_PIN-1:0] pin_pend_reg;
  logic [NUM_PIN-1:0] pin_clr;
  logic [NUM_INT:1] src_req;
  logic [NUM_INT:1] int_pend;
  logic [NUM_INT:1] eligible;
  logic [NUM_INT:1] in_service_reg;
  logic [NUM_INT:1] ins_set;
  logic [NUM_INT:1] ins_clr;
  logic [3:0] ins_top;
  logic [3:0] int_top;
  logic int_active;
  logic [2:0] ext_lvl;
  logic [2:0] present_lvl;
  logic accept;
  logic take_int;
  logic take_ext;
  logic [4:0] vec_low;

  function automatic logic [3:0] top_index(input logic [NUM_INT:1] v);
    top_index = SRC_NONE;
    for (int i = 1; i <= NUM_INT; i++) begin
      if (v[i]) begin
        top_index = 4'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs
  pic_pin_sync #(.W(6)) u_ext_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_n({priority_level_inputs_n, level_seven_request_line_n,
            level_six_request_line_n, level_one_request_line_n}),
    .active_reg(ext_active),
    .fall_reg()
  );

  pic_pin_sync #(.W(NUM_PIN)) u_pin_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_n(port_pins_n),
    .active_reg(pin_active),
    .fall_reg(pin_fall)
  );

  // Edge is latched: a short pin pulse must not be lost
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_pend_reg <= '0;
    end else begin
      pin_pend_reg <= (pin_pend_reg & ~pin_clr) | pin_fall;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal source requests
  genvar g;
  generate
    for (g = 0; g < NUM_PIN; g++) begin : g_pin
      assign src_req[PIN_FIRST+g] = pin_pend_reg[g];
      assign pin_clr[g] = ins_set[PIN_FIRST+g];
    end
    for (g = 0; g < NUM_PER; g++) begin : g_per
      assign src_req[PER_FIRST+g] =
        |(internal_source_request[g*EVT_W +: EVT_W] &
          ~event_mask[g*EVT_W +: EVT_W]);
    end
  endgenerate

  assign int_pend = src_req & ~source_mask;

  // Only sources above the one in service may nest
  always_comb begin
    ins_top = top_index(in_service_reg);
    for (int i = 1; i <= NUM_INT; i++) begin
      eligible[i] = int_pend[i] && (4'(i) > ins_top);
    end
    int_top = top_index(eligible);
    int_active = (int_top != SRC_NONE) && (internal_level != LVL_NONE);
  end

  ////////////////////////////////////////////////////////////////////////
  // External level and presented level
  always_comb begin
    if (!dedicated_mode) begin
      ext_lvl = ext_active[5:3];
    end else if (ext_active[2]) begin
      ext_lvl = LVL_SEVEN;
    end else if (ext_active[1]) begin
      ext_lvl = LVL_SIX;
    end else if (ext_active[0]) begin
      ext_lvl = LVL_ONE;
    end else begin
      ext_lvl = LVL_NONE;
    end
    if (int_active && internal_level >= ext_lvl) begin
      present_lvl = internal_level;
    end else begin
      present_lvl = ext_lvl;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      core_level_reg <= LEVEL_RST;
    end else begin
      core_level_reg <= present_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge decision; internal wins a tie of levels
  always_comb begin
    accept = iack_strobe && (state_reg == ST_IDLE);
    take_int = accept && int_active && (iack_level == internal_level);
    take_ext = accept && !take_int && (ext_lvl == iack_level) &&
               (ext_lvl != LVL_NONE);
    if (take_int) begin
      vec_low = {1'b0, int_top};
    end else if (take_ext) begin
      vec_low = VEC_EXT_BASE | {2'h0, iack_level};
    end else begin
      vec_low = VEC_SPURIOUS;
    end
    for (int i = 1; i <= NUM_INT; i++) begin
      ins_set[i] = take_int && (int_top == 4'(i));
      ins_clr[i] = eoi_strobe && (eoi_source == 4'(i));
    end
  end

  // Set wins over an end of service in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      in_service_reg <= '0;
    end else begin
      in_service_reg <= (in_service_reg & ~ins_clr) | ins_set;
    end
  end

  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = accept ? ST_ANSWER : ST_IDLE;
      ST_ANSWER: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      vec_valid_reg <= 1'b0;
      vec_data_reg <= VECTOR_RST;
    end else begin
      vec_valid_reg <= accept;
      if (accept) begin
        vec_data_reg <= {vector_base, vec_low};
      end
    end
  end

  // Acknowledge pins exist only for the dedicated lines
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_ack_n_reg <= ACK_N_RST;
    end else begin
      ext_ack_n_reg <= ACK_N_RST;
      if (take_ext && dedicated_mode) begin
        if (iack_level == LVL_SEVEN) begin
          ext_ack_n_reg[ACK_SEVEN] <= !ack_pair_en[ACK_SEVEN];
        end
        if (iack_level == LVL_SIX) begin
          ext_ack_n_reg[ACK_SIX] <= !ack_pair_en[ACK_SIX];
        end
        if (iack_level == LVL_ONE) begin
          ext_ack_n_reg[ACK_ONE] <= !ack_pair_en[ACK_ONE];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_ack_answer: assert property (@(posedge sys_clk) disable iff (reset)
    accept |=> vec_valid_reg ##1 !vec_valid_reg)
    else $error("acknowledge not answered in one cycle");

  chk_nest_above: assert property (@(posedge sys_clk) disable iff (reset)
    take_int |-> (int_top > ins_top) ##1 in_service_reg[$past(int_top)])
    else $error("nested grant not above service level");

  chk_mask_silent: assert property (@(posedge sys_clk) disable iff (reset)
    (source_mask == '1) && (ext_lvl == LVL_NONE) |=>
      core_level_reg == LVL_NONE)
    else $error("masked sources raised a level");

  chk_event_gate: assert property (@(posedge sys_clk) disable iff (reset)
    src_req[PER_FIRST] |->
      (internal_source_request[EVT_W-1:0] & ~event_mask[EVT_W-1:0]) != 0)
    else $error("masked event raised a source");

  chk_normal_level: assert property (@(posedge sys_clk) disable iff (reset)
    !dedicated_mode && !int_active |=> core_level_reg == $past(ext_active[5:3]))
    else $error("encoded level not presented");

  chk_ded_seven: assert property (@(posedge sys_clk) disable iff (reset)
    dedicated_mode && ext_active[2] && !int_active |=>
      core_level_reg == LVL_SEVEN)
    else $error("dedicated line seven not at level seven");

  chk_ext_vector: assert property (@(posedge sys_clk) disable iff (reset)
    take_ext |=> vec_data_reg[4:0] == (VEC_EXT_BASE | {2'h0, $past(iack_level)}))
    else $error("external vector wrong");

  chk_int_vector: assert property (@(posedge sys_clk) disable iff (reset)
    take_int |=> vec_data_reg[4:0] == {1'b0, $past(int_top)})
    else $error("internal vector wrong");

  chk_ack_pin: assert property (@(posedge sys_clk) disable iff (reset)
    take_ext && dedicated_mode && (iack_level == LVL_SEVEN) &&
      ack_pair_en[ACK_SEVEN] |=> !ext_ack_n_reg[ACK_SEVEN] ##1
      ext_ack_n_reg[ACK_SEVEN])
    else $error("acknowledge pin seven not pulsed");

  chk_pin_hold: assert property (@(posedge sys_clk) disable iff (reset)
    pin_fall[0] |=> pin_pend_reg[0])
    else $error("port pin edge lost");

  chk_highest: assert property (@(posedge sys_clk) disable iff (reset)
    int_active |-> eligible[int_top] && ((eligible >> int_top) == '0))
    else $error("presented source not highest");
endmodule // pic_ctrl

// ==== hdl/pic_pin_sync.sv ====
`timescale 1ns/1ps
module pic_pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Pins, active low
  input wire logic [W-1:0] pin_n,
  // Synchronised view
  output logic [W-1:0] active_reg,
  output logic [W-1:0] fall_reg
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] agree;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= pin_n;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Glitch of one cycle never reaches the stable view
  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      active_reg <= '0;
      fall_reg <= '0;
    end else begin
      active_reg <= (active_reg & ~agree) | (~s2_reg & agree);
      fall_reg <= ~active_reg & ~s2_reg & agree;
    end
  end
endmodule // pic_pin_sync

// ==== hdl/pic_pkg.sv ====
package pic_pkg;
  // Source counts
  localparam int NUM_INT = 15;
  localparam int NUM_PER = 11;
  localparam int NUM_PIN = 4;
  localparam int EVT_W = 4;
  localparam int NUM_EXT = 3;
  localparam int NUM_SRC = NUM_INT + NUM_EXT;
  // Internal source numbering, higher number wins
  localparam int PIN_FIRST = 1;
  localparam int PER_FIRST = PIN_FIRST + NUM_PIN;
  localparam logic [3:0] SRC_NONE = 4'h0;
  // Priority levels
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_SEVEN = 3'h7;
  localparam logic [2:0] LVL_SIX = 3'h6;
  localparam logic [2:0] LVL_ONE = 3'h1;
  // Acknowledge pin bit per dedicated line
  localparam int ACK_SEVEN = 2;
  localparam int ACK_SIX = 1;
  localparam int ACK_ONE = 0;
  // Vector low field encodings
  localparam logic [4:0] VEC_SPURIOUS = 5'h00;
  localparam logic [4:0] VEC_EXT_BASE = 5'h10;
  // Reset values
  localparam logic [2:0] LEVEL_RST = 3'h0;
  localparam logic [7:0] VECTOR_RST = 8'h00;
  localparam logic [2:0] ACK_N_RST = 3'h7;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } pic_state_e;
endpackage

// ==== sim/pic_core_model.sv ====
`timescale 1ns/1ps
module pic_core_model
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Bench commands
  input wire logic ack_go,
  input wire logic [2:0] ack_lvl,
  input wire logic eoi_go,
  input wire logic [3:0] eoi_src,
  // Controller side
  input wire logic vec_valid_reg,
  input wire logic [7:0] vec_data_reg,
  input wire logic [NUM_EXT-1:0] ext_ack_n_reg,
  output logic iack_strobe,
  output logic [2:0] iack_level,
  output logic eoi_strobe,
  output logic [3:0] eoi_source,
  output logic [7:0] vec_seen,
  output logic [NUM_EXT-1:0] ack_seen,
  output logic [7:0] seen_cnt
);
  logic ack_req = 1'b0;
  logic eoi_req = 1'b0;
  logic [2:0] lvl_hold;
  logic [3:0] src_hold;
  initial begin
    iack_strobe = 1'b0;
    iack_level = 3'h5;
    eoi_strobe = 1'b0;
    eoi_source = 4'hA;
    seen_cnt = 8'h00;
  end
  always @(posedge sys_clk) begin
    ack_req <= ack_go;
    eoi_req <= eoi_go;
    lvl_hold <= ack_lvl;
    src_hold <= eoi_src;
    if (reset) begin
      seen_cnt <= 8'h00;
    end else if (vec_valid_reg) begin
      vec_seen <= vec_data_reg;
      ack_seen <= ext_ack_n_reg;
      seen_cnt <= seen_cnt + 8'h01;
    end
  end
  // Qualifiers flip outside strobes so stale values never look valid
  always @(negedge sys_clk) begin
    iack_strobe <= ack_req;
    iack_level <= ack_req ? lvl_hold : ~iack_level;
    eoi_strobe <= eoi_req;
    eoi_source <= eoi_req ? src_hold : ~eoi_source;
  end
endmodule // pic_core_model

// ==== sim/test_priority_interrupt_controller.sv ====
`timescale 1ns/1ps
module test_priority_interrupt_controller
  import pic_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset, dedicated_mode, ack_go, eoi_go, vec_valid_reg;
  logic iack_strobe, eoi_strobe;
  logic [2:0] internal_level, vector_base, ack_pair_en, pli_n, line_n;
  logic [2:0] ack_lvl, iack_level, core_level_reg, ext_ack_n_reg, ack_seen;
  logic [43:0] isr, event_mask;
  logic [15:1] source_mask;
  logic [3:0] port_pins_n, eoi_src, eoi_source;
  logic [7:0] vec_data_reg, vec_seen, seen_cnt;
  logic [31:0] lfsr;
  int n_mismatch = 0;
  int tests_run = 0;
  int e;
  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  pic_ctrl dut (.sys_clk(sys_clk), .reset(reset),
    .dedicated_mode(dedicated_mode), .internal_level(internal_level),
    .vector_base(vector_base), .ack_pair_en(ack_pair_en),
    .internal_source_request(isr), .event_mask(event_mask),
    .source_mask(source_mask), .port_pins_n(port_pins_n),
    .priority_level_inputs_n(pli_n),
    .level_seven_request_line_n(line_n[ACK_SEVEN]),
    .level_six_request_line_n(line_n[ACK_SIX]),
    .level_one_request_line_n(line_n[ACK_ONE]),
    .iack_strobe(iack_strobe), .iack_level(iack_level),
    .eoi_strobe(eoi_strobe), .eoi_source(eoi_source),
    .core_level_reg(core_level_reg), .vec_valid_reg(vec_valid_reg),
    .vec_data_reg(vec_data_reg), .ext_ack_n_reg(ext_ack_n_reg));
  pic_core_model core (.sys_clk(sys_clk), .reset(reset), .ack_go(ack_go),
    .ack_lvl(ack_lvl), .eoi_go(eoi_go), .eoi_src(eoi_src),
    .vec_valid_reg(vec_valid_reg), .vec_data_reg(vec_data_reg),
    .ext_ack_n_reg(ext_ack_n_reg), .iack_strobe(iack_strobe),
    .iack_level(iack_level), .eoi_strobe(eoi_strobe),
    .eoi_source(eoi_source), .vec_seen(vec_seen), .ack_seen(ack_seen),
    .seen_cnt(seen_cnt));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [4:0] int_vec(input int s);
    return 5'(s);
  endfunction
  function automatic logic [4:0] ext_vec(input logic [2:0] l);
    return VEC_EXT_BASE | {2'b00, l};
  endfunction
  function automatic logic [2:0] ded_lvl(input int k);
    return (k == ACK_SEVEN) ? LVL_SEVEN : (k == ACK_SIX) ? LVL_SIX : LVL_ONE;
  endfunction
  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Level outputs trail the pin syncs, so settle well past them
  task automatic level_is(input logic [2:0] want);
    tick(8);
    check({5'h00, core_level_reg}, {5'h00, want});
  endtask
  task automatic ack(input logic [2:0] lvl, input logic [4:0] low5,
                     input logic [2:0] ack_want);
    logic [7:0] cnt0;
    cnt0 = seen_cnt;
    ack_go = 1'b1;
    ack_lvl = lvl;
    tick(1);
    ack_go = 1'b0;
    for (int i = 0; i < 8 && seen_cnt == cnt0; i++) tick(1);
    // A missing answer would otherwise compare a stale vector
    check(seen_cnt, cnt0 + 8'h01);
    check(vec_seen, {vector_base, low5});
    check({5'h00, ack_seen}, {5'h00, ack_want});
  endtask
  task automatic eoi(input logic [3:0] src);
    eoi_go = 1'b1;
    eoi_src = src;
    tick(1);
    eoi_go = 1'b0;
    tick(3);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report;
  end
  initial begin
    lfsr = 32'h31C7;
    {reset, pli_n, line_n, port_pins_n} = {1'b1, 3'h7, 3'h7, 4'hF};
    {dedicated_mode, ack_go, eoi_go, ack_lvl, eoi_src} = '0;
    {isr, event_mask, source_mask} = '0;
    internal_level = 3'h4;
    vector_base = lfsr[2:0];
    ack_pair_en = 3'h7;
    tick(3);
    reset = 1'b0;
    check(vec_data_reg, VECTOR_RST);
    check({5'h00, ext_ack_n_reg}, {5'h00, ACK_N_RST});
    check({5'h00, core_level_reg}, {5'h00, LEVEL_RST});
    $display("test reset done");
    for (int p = 0; p < NUM_PER; p++) begin
      lfsr = lfsr_next(lfsr);
      e = 4 * p + int'(lfsr[1:0]);
      event_mask[e] = 1'b1;
      isr[e] = 1'b1;
      level_is(LVL_NONE);
      event_mask[e] = 1'b0;
      source_mask[p + PER_FIRST] = 1'b1;
      level_is(LVL_NONE);
      source_mask[p + PER_FIRST] = 1'b0;
      level_is(internal_level);
      ack(internal_level, int_vec(p + PER_FIRST), ACK_N_RST);
      isr[e] = 1'b0;
      eoi(4'(p + PER_FIRST));
    end
    $display("test peripheral sources done");
    for (int i = 0; i < NUM_PIN; i++) begin
      port_pins_n[i] = 1'b0;
      level_is(internal_level);
      ack(internal_level, int_vec(i + PIN_FIRST), ACK_N_RST);
      eoi(4'(i + PIN_FIRST));
      level_is(LVL_NONE);
      port_pins_n[i] = 1'b1;
    end
    $display("test port pins done");
    isr[0] = 1'b1;
    isr[43] = 1'b1;
    source_mask[15] = 1'b1;
    level_is(internal_level);
    source_mask = '1;
    level_is(LVL_NONE);
    source_mask = '0;
    level_is(internal_level);
    ack(internal_level, int_vec(15), ACK_N_RST);
    isr[43] = 1'b0;
    level_is(LVL_NONE);
    eoi(4'hF);
    level_is(internal_level);
    ack(internal_level, int_vec(5), ACK_N_RST);
    isr[0] = 1'b0;
    isr[40] = 1'b1;
    level_is(internal_level);
    ack(internal_level, int_vec(15), ACK_N_RST);
    isr[40] = 1'b0;
    eoi(4'hF);
    eoi(4'h5);
    $display("test priority and nesting done");
    for (int l = 1; l < 8; l++) begin
      pli_n = ~3'(l);
      level_is(3'(l));
      ack(3'(l), ext_vec(3'(l)), ACK_N_RST);
    end
    pli_n = 3'h7;
    tick(8);
    ack(3'h3, VEC_SPURIOUS, ACK_N_RST);
    $display("test normal mode done");
    dedicated_mode = 1'b1;
    for (int k = 0; k < NUM_EXT; k++) begin
      for (int en = 0; en < 2; en++) begin
        ack_pair_en = en ? 3'h7 : 3'h0;
        line_n[k] = 1'b0;
        level_is(ded_lvl(k));
        ack(ded_lvl(k), ext_vec(ded_lvl(k)),
            en ? ~(3'h1 << k) : ACK_N_RST);
        line_n[k] = 1'b1;
      end
    end
    $display("test dedicated mode done");
    final_report;
  end
endmodule // test_priority_interrupt_controller
